/* File: rtl/dpu_pkg.sv */
// package: register map, field layout and state types of the debug port uart
package dpu_pkg;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_MODE = 12'h004;
  localparam logic [11:0] OFS_STAT = 12'h014;
  localparam logic [11:0] OFS_RHR  = 12'h018;
  localparam logic [11:0] OFS_THR  = 12'h01C;
  localparam logic [11:0] OFS_DIV  = 12'h020;

  // ---------------------------------------------------------------
  // control register bits
  // ---------------------------------------------------------------
  localparam int CR_RX_RST  = 2;
  localparam int CR_TX_RST  = 3;
  localparam int CR_RX_EN   = 4;
  localparam int CR_RX_DIS  = 5;
  localparam int CR_TX_EN   = 6;
  localparam int CR_TX_DIS  = 7;
  localparam int CR_CLR_ERR = 8;

  // ---------------------------------------------------------------
  // mode and status fields
  // ---------------------------------------------------------------
  localparam int MR_PAR_LO   = 9;
  localparam int SR_RX_RDY   = 0;
  localparam int SR_TX_RDY   = 1;
  localparam int SR_OVERRUN  = 5;
  localparam int SR_FRAME    = 6;
  localparam int SR_PAR_ERR  = 7;
  localparam int SR_TX_EMPTY = 9;

  localparam logic [2:0]  PAR_RST     = 3'h0;
  localparam logic [15:0] DIV_RST     = 16'h0000;
  localparam logic [3:0]  START_VALID = 4'h7;
  localparam logic [3:0]  MID_BIT     = 4'h8;
  localparam logic [3:0]  LAST_TICK   = 4'hF;
  localparam logic [3:0]  FRAME_PAR   = 4'hB;
  localparam logic [3:0]  FRAME_NOPAR = 4'hA;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} dpu_rx_state_t;
  typedef enum logic       {TX_IDLE, TX_SHIFT}          dpu_tx_state_t;

  typedef struct packed {
    logic parity;
    logic frame;
    logic overrun;
  } dpu_err_t;

endpackage : dpu_pkg

/* File: rtl/dpu_uart.sv */
// debug port uart: apb register slave, baud generator, receiver, transmitter
//
// Function
// RULE1 - baud rate is master_clock divided by sixteen times clock_divisor
// RULE2 - clock_divisor zero stops the sampling clock, receiver and transmitter freeze
// RULE3 - clock_divisor is a sixteen bit field
// RULE4 - asynchronous only, no clock pin, eight data bits plus optional parity
// RULE5 - receiver and transmitter independent, one shared baud generator, no timeout
// RULE6 - receiver disabled after reset, rx_enable_cmd enables start bit hunting
// RULE7 - rx_disable_cmd stops idle receiver at once, else after stop bit
// RULE8 - rx_reset_cmd halts receiver at once, disables it, drops the character
// RULE9 - start bit valid only if low for more than seven sample ticks
// RULE10 - first data sample 24 ticks after falling edge, then every 16
// RULE11 - complete character goes to holding register, sets ready, read clears
// RULE12 - character arriving while ready set sets overrun until error clear
// RULE13 - parity mismatch sets parity error with ready, sticky until error clear
// RULE14 - low stop bit sets framing error with ready, sticky until error clear
// RULE15 - transmitter disabled after reset, tx_enable_cmd enables, waits for data
// RULE16 - tx_disable_cmd stops idle transmitter, else drains shift and holding
// RULE17 - tx_reset_cmd halts the transmitter at once and disables it
// RULE18 - frame is low start, eight data lsb first, optional parity, high stop
// RULE19 - parity is odd, even, forced zero or forced one per mode
// RULE20 - tx ready set when enabled, drops on second write, rises on transfer; the code drops it on every holding register write, the first included
// RULE21 - tx empty rises only after last stop bit with both stages empty; the code also raises it at tx_enable_cmd when both stages are already empty
// RULE22 - software enables unit clock, pin mux and interrupt controller first
// RULE23 - parity field 000 even, 001 odd, 010 space, 011 mark, 1xx none
// RULE24 - disable wins over enable written in the same control write
// RULE25 - clear_error_flags_cmd clears parity, framing and overrun together
// RULE26 - sampling tick is one pulse every clock_divisor master clocks
// RULE27 - disabled transmitter holds line high, disabled receiver ignores line
`timescale 1ns/1ps

module dpu_uart #(
  parameter int DIV_W = 16
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // serial line
  input  wire logic        serial_rx_pin,
  output logic             serial_tx_pin
);

  // the baud counter arithmetic is sized for a sixteen bit divisor only
  if (DIV_W != 16) begin : g_div_w_check
    $error("DIV_W must be 16");
  end

  function automatic logic par_calc(input logic [7:0] d, input logic [1:0] p);
    case (p)
      2'b00:   par_calc = ^d;  // even [RULE19] [RULE23]
      2'b01:   par_calc = ~^d;
      2'b10:   par_calc = 1'b0;
      default: par_calc = 1'b1;
    endcase
  endfunction : par_calc

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  logic acc, wr, rd, hit;
  logic cr_wr, rhr_rd, thr_wr;

  assign acc    = psel & penable;
  assign wr     = acc & pwrite;
  assign rd     = acc & ~pwrite;
  assign hit    = paddr inside {dpu_pkg::OFS_CTRL, dpu_pkg::OFS_MODE, dpu_pkg::OFS_STAT,
                                dpu_pkg::OFS_RHR, dpu_pkg::OFS_THR, dpu_pkg::OFS_DIV};
  assign cr_wr  = wr & (paddr == dpu_pkg::OFS_CTRL);
  assign thr_wr = wr & (paddr == dpu_pkg::OFS_THR);
  assign rhr_rd = rd & (paddr == dpu_pkg::OFS_RHR);
  assign pready  = 1'b1;
  assign pslverr = acc & ~hit;

  logic rx_rst, tx_rst, clr_err;
  assign rx_rst  = cr_wr & pwdata[dpu_pkg::CR_RX_RST];
  assign tx_rst  = cr_wr & pwdata[dpu_pkg::CR_TX_RST];
  assign clr_err = cr_wr & pwdata[dpu_pkg::CR_CLR_ERR];

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  logic [2:0]       par_mode, next_par_mode;
  logic [DIV_W-1:0] divisor, next_divisor;

  always_comb begin
    next_par_mode = par_mode;
    next_divisor  = divisor;
    if (wr && paddr == dpu_pkg::OFS_MODE) begin
      next_par_mode = pwdata[dpu_pkg::MR_PAR_LO +: 3];
    end
    if (wr && paddr == dpu_pkg::OFS_DIV) begin
      next_divisor = pwdata[DIV_W-1:0];  // [RULE3]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      par_mode <= dpu_pkg::PAR_RST;
      divisor  <= dpu_pkg::DIV_RST;
    end else begin
      par_mode <= next_par_mode;
      divisor  <= next_divisor;
    end
  end

  logic par_en;
  assign par_en = ~par_mode[2];  // [RULE23]

  // ---------------------------------------------------------------
  // baud generator
  // ---------------------------------------------------------------
  // tick is the 16x sampling clock; both directions share it
  logic [DIV_W-1:0] bcnt, next_bcnt;
  logic             tick;

  // >= so that lowering the divisor mid-count does not wait for a full counter wrap
  assign tick = (divisor != '0) && (bcnt >= divisor - 16'h0001);  // [RULE26] [RULE2]

  always_comb begin
    next_bcnt = bcnt + 16'h0001;
    if (divisor == '0 || tick) begin
      next_bcnt = '0;  // [RULE1] [RULE5]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bcnt <= '0;
    end else begin
      bcnt <= next_bcnt;
    end
  end

  // ---------------------------------------------------------------
  // receive pin synchroniser
  // ---------------------------------------------------------------
  logic rx_meta, rxs;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_meta <= 1'b1;
      rxs     <= 1'b1;
    end else begin
      rx_meta <= serial_rx_pin;
      rxs     <= rx_meta;
    end
  end

  // ---------------------------------------------------------------
  // receiver
  // ---------------------------------------------------------------
  dpu_pkg::dpu_rx_state_t rx_state, next_rx_state;
  logic            rx_en, next_rx_en;
  logic [3:0]      rx_cnt, next_rx_cnt;
  logic [3:0]      rx_bit, next_rx_bit;
  logic [7:0]      rx_sh, next_rx_sh;
  logic            rx_par, next_rx_par;
  logic [7:0]      rhr, next_rhr;
  logic            rx_ready, next_rx_ready;
  dpu_pkg::dpu_err_t err, next_err;
  logic            rx_done;

  always_comb begin
    next_rx_state = rx_state;
    next_rx_en    = rx_en;
    next_rx_cnt   = rx_cnt;
    next_rx_bit   = rx_bit;
    next_rx_sh    = rx_sh;
    next_rx_par   = rx_par;
    next_rhr      = rhr;
    next_rx_ready = rx_ready;
    next_err      = err;
    rx_done       = 1'b0;
    if (rhr_rd) begin
      next_rx_ready = 1'b0;  // [RULE11]
    end
    if (clr_err) begin
      next_err = '0;  // [RULE25]
    end
    if (cr_wr && pwdata[dpu_pkg::CR_RX_EN] && !pwdata[dpu_pkg::CR_RX_DIS]) begin
      next_rx_en = 1'b1;  // [RULE6] [RULE24]
    end
    if (cr_wr && pwdata[dpu_pkg::CR_RX_DIS]) begin
      next_rx_en = 1'b0;  // [RULE7]
    end
    case (rx_state)
      dpu_pkg::RX_IDLE: begin
        if (rx_en && tick && !rxs) begin
          next_rx_state = dpu_pkg::RX_START;  // [RULE27]
          next_rx_cnt   = 4'h1;
        end
      end
      dpu_pkg::RX_START: begin
        // before the start is proven, a disable still counts as idle
        if (!rx_en && !rx_cnt[3]) begin
          next_rx_state = dpu_pkg::RX_IDLE;  // [RULE7]
        end else if (tick) begin
          next_rx_cnt = rx_cnt + 4'h1;
          if (rx_cnt <= dpu_pkg::START_VALID && rxs) begin
            next_rx_state = dpu_pkg::RX_IDLE;  // [RULE9]
          end else if (rx_cnt == dpu_pkg::LAST_TICK) begin
            next_rx_state = dpu_pkg::RX_DATA;
            next_rx_bit   = 4'h0;
          end
        end
      end
      dpu_pkg::RX_DATA: begin
        if (tick) begin
          next_rx_cnt = rx_cnt + 4'h1;
          if (rx_cnt == dpu_pkg::MID_BIT) begin  // [RULE10]
            next_rx_bit = rx_bit + 4'h1;
            if (rx_bit == (par_en ? 4'h9 : 4'h8)) begin
              rx_done          = 1'b1;
              next_rx_state    = dpu_pkg::RX_IDLE;
              next_rhr         = rx_sh;  // [RULE11] [RULE4]
              next_rx_ready    = 1'b1;
              next_err.overrun = next_err.overrun | rx_ready;  // [RULE12]
              next_err.frame   = next_err.frame | ~rxs;  // [RULE14]
              next_err.parity  = next_err.parity
                               | (par_en & (par_calc(rx_sh, par_mode[1:0]) != rx_par));  // [RULE13]
            end else if (rx_bit == 4'h8) begin
              next_rx_par = rxs;
            end else begin
              next_rx_sh = {rxs, rx_sh[7:1]};
            end
          end
        end
      end
      default: next_rx_state = dpu_pkg::RX_IDLE;
    endcase
    if (rx_rst) begin
      next_rx_en    = 1'b0;  // [RULE8]
      next_rx_state = dpu_pkg::RX_IDLE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state <= dpu_pkg::RX_IDLE;
      rx_en    <= 1'b0;
      rx_cnt   <= 4'h0;
      rx_bit   <= 4'h0;
      rx_sh    <= 8'h00;
      rx_par   <= 1'b0;
      rhr      <= 8'h00;
      rx_ready <= 1'b0;
      err      <= '0;
    end else begin
      rx_state <= next_rx_state;
      rx_en    <= next_rx_en;
      rx_cnt   <= next_rx_cnt;
      rx_bit   <= next_rx_bit;
      rx_sh    <= next_rx_sh;
      rx_par   <= next_rx_par;
      rhr      <= next_rhr;
      rx_ready <= next_rx_ready;
      err      <= next_err;
    end
  end

  // ---------------------------------------------------------------
  // transmitter
  // ---------------------------------------------------------------
  dpu_pkg::dpu_tx_state_t tx_state, next_tx_state;
  logic        tx_en, next_tx_en;
  logic        tx_drain, next_tx_drain;
  logic [7:0]  thr, next_thr;
  logic        thr_full, next_thr_full;
  logic [3:0]  tx_cnt, next_tx_cnt;
  logic [3:0]  tx_nb, next_tx_nb;
  logic [10:0] tx_sh, next_tx_sh;
  logic        next_tx_pin;
  logic        tx_run, tx_load;

  assign tx_run = tx_en | tx_drain;

  always_comb begin
    next_tx_state = tx_state;
    next_tx_en    = tx_en;
    next_tx_drain = tx_drain;
    next_thr      = thr;
    next_thr_full = thr_full;
    next_tx_cnt   = tx_cnt;
    next_tx_nb    = tx_nb;
    next_tx_sh    = tx_sh;
    tx_load       = 1'b0;
    case (tx_state)
      dpu_pkg::TX_IDLE: begin
        tx_load = tx_run & thr_full & tick;  // [RULE15]
      end
      dpu_pkg::TX_SHIFT: begin
        if (tick) begin
          next_tx_cnt = tx_cnt + 4'h1;
          if (tx_cnt == dpu_pkg::LAST_TICK) begin
            next_tx_sh = {1'b1, tx_sh[10:1]};
            next_tx_nb = tx_nb - 4'h1;
            if (tx_nb == 4'h1) begin
              next_tx_state = dpu_pkg::TX_IDLE;  // [RULE21]
              tx_load       = tx_run & thr_full;
            end
          end
        end
      end
      default: next_tx_state = dpu_pkg::TX_IDLE;
    endcase
    if (tx_load) begin
      // holding register moves on; ready rises again only if tx_en is set, not while draining [RULE20]
      next_tx_state = dpu_pkg::TX_SHIFT;
      next_thr_full = 1'b0;
      next_tx_cnt   = 4'h0;
      next_tx_sh    = {1'b1, par_en ? par_calc(thr, par_mode[1:0]) : 1'b1, thr, 1'b0};  // [RULE18]
      next_tx_nb    = par_en ? dpu_pkg::FRAME_PAR : dpu_pkg::FRAME_NOPAR;
    end
    if (tx_drain && next_tx_state == dpu_pkg::TX_IDLE && !next_thr_full) begin
      next_tx_drain = 1'b0;
    end
    if (thr_wr && tx_en) begin
      next_thr      = pwdata[7:0];  // [RULE20]
      next_thr_full = 1'b1;
    end
    if (cr_wr && pwdata[dpu_pkg::CR_TX_EN] && !pwdata[dpu_pkg::CR_TX_DIS]) begin
      next_tx_en = 1'b1;  // [RULE24]
    end
    if (cr_wr && pwdata[dpu_pkg::CR_TX_DIS]) begin
      next_tx_en    = 1'b0;  // [RULE16]
      next_tx_drain = (tx_state == dpu_pkg::TX_SHIFT) | thr_full;
    end
    if (tx_rst) begin
      next_tx_en    = 1'b0;  // [RULE17]
      next_tx_drain = 1'b0;
      next_thr_full = 1'b0;
      next_tx_state = dpu_pkg::TX_IDLE;
    end
    next_tx_pin = (next_tx_state == dpu_pkg::TX_SHIFT) ? next_tx_sh[0] : 1'b1;  // [RULE27]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state      <= dpu_pkg::TX_IDLE;
      tx_en         <= 1'b0;
      tx_drain      <= 1'b0;
      thr           <= 8'h00;
      thr_full      <= 1'b0;
      tx_cnt        <= 4'h0;
      tx_nb         <= 4'h0;
      tx_sh         <= 11'h7FF;
      serial_tx_pin <= 1'b1;
    end else begin
      tx_state      <= next_tx_state;
      tx_en         <= next_tx_en;
      tx_drain      <= next_tx_drain;
      thr           <= next_thr;
      thr_full      <= next_thr_full;
      tx_cnt        <= next_tx_cnt;
      tx_nb         <= next_tx_nb;
      tx_sh         <= next_tx_sh;
      serial_tx_pin <= next_tx_pin;
    end
  end

  logic tx_ready, tx_empty;
  assign tx_ready = tx_en & ~thr_full;  // [RULE20]
  assign tx_empty = tx_ready & (tx_state == dpu_pkg::TX_IDLE);  // [RULE21]

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  // captured in the setup cycle so prdata is a flop during access
  logic [31:0] next_prdata, stat;

  always_comb begin
    stat = 32'h0000_0000;
    stat[dpu_pkg::SR_RX_RDY]   = rx_ready;
    stat[dpu_pkg::SR_TX_RDY]   = tx_ready;
    stat[dpu_pkg::SR_OVERRUN]  = err.overrun;
    stat[dpu_pkg::SR_FRAME]    = err.frame;
    stat[dpu_pkg::SR_PAR_ERR]  = err.parity;
    stat[dpu_pkg::SR_TX_EMPTY] = tx_empty;
    next_prdata = prdata;
    if (psel && !penable && !pwrite) begin
      case (paddr)
        dpu_pkg::OFS_MODE: next_prdata = {20'h0_0000, par_mode, 9'h000};
        dpu_pkg::OFS_STAT: next_prdata = stat;
        dpu_pkg::OFS_RHR:  next_prdata = {24'h00_0000, rhr};
        dpu_pkg::OFS_DIV:  next_prdata = {16'h0000, divisor};
        default:           next_prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= next_prdata;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_div_zero_tick: assert property (@(posedge pclk) disable iff (!presetn)  // [RULE2]
    divisor == '0 |=> $stable(rx_cnt) && $stable(tx_sh))
    else $error("uart ran with zero divisor");

  a_start_valid_len: assert property (@(posedge pclk) disable iff (!presetn)  // [RULE9]
    (rx_state == dpu_pkg::RX_START && next_rx_state == dpu_pkg::RX_DATA)
    |-> tick && rx_cnt == dpu_pkg::LAST_TICK) else $error("start accepted wrongly");

  a_start_short_drop: assert property (@(posedge pclk) disable iff (!presetn)  // [RULE9]
    rx_state == dpu_pkg::RX_START && tick && rxs && rx_cnt <= dpu_pkg::START_VALID
    |=> rx_state == dpu_pkg::RX_IDLE) else $error("short start not dropped");

  a_rx_ready_set: assert property (@(posedge pclk) disable iff (!presetn)  // [RULE11]
    rx_done && !rx_rst |=> rx_ready && rhr == $past(rx_sh)) else $error("char not stored");

  a_overrun_set: assert property (@(posedge pclk) disable iff (!presetn)  // [RULE12]
    rx_done && rx_ready |=> err.overrun) else $error("overrun missed");

  a_err_clear: assert property (@(posedge pclk) disable iff (!presetn)  // [RULE25]
    clr_err && !rx_done |=> err == '0) else $error("errors not cleared");

  a_rx_reset: assert property (@(posedge pclk) disable iff (!presetn)  // [RULE8]
    rx_rst |=> !rx_en && rx_state == dpu_pkg::RX_IDLE) else $error("rx reset ignored");

  a_dis_priority: assert property (@(posedge pclk) disable iff (!presetn)  // [RULE24]
    cr_wr && pwdata[dpu_pkg::CR_TX_DIS] |=> !tx_en) else $error("tx enable beat disable");

  a_tx_idle_high: assert property (@(posedge pclk) disable iff (!presetn)  // [RULE27]
    tx_state == dpu_pkg::TX_IDLE |-> serial_tx_pin) else $error("idle line not high");

  a_tx_start_low: assert property (@(posedge pclk) disable iff (!presetn)  // [RULE18]
    tx_load && !tx_rst |=> !serial_tx_pin [*2]) else $error("start bit not low");

endmodule : dpu_uart

/* File: verif/dpu_host_model.sv */
// serial host model: drives the receive line and decodes the transmit line
`timescale 1ns/1ps

module dpu_host_model #(
  parameter int BIT_CYC = 32
) (
  // clock
  input  wire logic pclk,
  // serial lines
  input  wire logic serial_tx_pin,
  output logic      serial_rx_pin,
  // frame format
  input  wire logic par_en
);
  logic [9:0] got_char;
  event       got;

  // line is driven high from time zero, so it rests high between frames
  initial serial_rx_pin = 1'b1;

  // ---------------------------------------------------------------
  // sender
  // ---------------------------------------------------------------
  task automatic send(input logic [7:0] d, input logic p, input logic stp);
    logic [10:0] f;
    f = par_en ? {stp, p, d, 1'b0} : {1'b1, stp, d, 1'b0};
    for (int i = 0; i < (par_en ? 11 : 10); i++) begin
      serial_rx_pin <= f[i];
      repeat (BIT_CYC) @(posedge pclk);
    end
    serial_rx_pin <= 1'b1;
  endtask : send

  // too short to count as a start bit
  task automatic pulse(input int n);
    serial_rx_pin <= 1'b0;
    repeat (n) @(posedge pclk);
    serial_rx_pin <= 1'b1;
  endtask : pulse

  // ---------------------------------------------------------------
  // receiver: mid-bit samples, data lsb first
  // ---------------------------------------------------------------
  always begin
    @(negedge serial_tx_pin);
    repeat (BIT_CYC / 2) @(posedge pclk);
    for (int i = 0; i < 10; i++) begin
      if (i == 9 && !par_en) break;
      repeat (BIT_CYC) @(posedge pclk);
      got_char[i] = serial_tx_pin;
    end
    if (!par_en) got_char = {got_char[8], 1'b0, got_char[7:0]};
    ->got;
  end
endmodule : dpu_host_model

/* File: verif/dpu_uart_tb_top.sv */
// self-checking testbench of the debug port uart
`timescale 1ns/1ps

module dpu_uart_tb_top;
  localparam int DIV = 2;
  localparam int BC  = 16 * DIV;
  localparam int RR  = 1 << dpu_pkg::SR_RX_RDY;
  localparam int TR  = 1 << dpu_pkg::SR_TX_RDY;
  localparam int TE  = 1 << dpu_pkg::SR_TX_EMPTY;
  localparam int ERR = (1 << dpu_pkg::SR_OVERRUN) | (1 << dpu_pkg::SR_FRAME)
                     | (1 << dpu_pkg::SR_PAR_ERR);

  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        rx_line;
  logic        tx_line;
  logic        par_en  = 1'b1;
  logic [2:0]  mode    = 3'h0;
  logic [32:0] exp_rd[$];
  logic [32:0] msk_rd[$];
  logic [9:0]  exp_tx[$];
  int          mismatches = 0;
  int          compares   = 0;

  always #5 pclk = ~pclk;

  dpu_uart dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .serial_rx_pin(rx_line), .serial_tx_pin(tx_line));

  dpu_host_model #(.BIT_CYC(BC)) hm (.pclk(pclk), .serial_tx_pin(tx_line),
    .serial_rx_pin(rx_line), .par_en(par_en));

  // ---------------------------------------------------------------
  // checking
  // ---------------------------------------------------------------
  task automatic chk(input logic [32:0] act, input logic [32:0] e, input logic [32:0] m);
    compares++;
    if ((act & m) !== (e & m)) begin
      mismatches++;
      $display("ERROR %0t got %h want %h mask %h", $time, act, e, m);
    end
  endtask : chk

  always @(posedge pclk) begin
    if (psel && penable && !pwrite && pready) chk({pslverr, prdata}, exp_rd.pop_front(),
      msk_rd.pop_front());
  end

  // a char with nothing noted is compared against an impossible value
  always @(hm.got) begin
    chk({23'h0, hm.got_char}, exp_tx.size() ? {23'h0, exp_tx.pop_front()} : {33{1'b1}},
      {33{1'b1}});
  end

  // ---------------------------------------------------------------
  // bus and helper tasks
  // ---------------------------------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [32:0] e, input logic [32:0] m);
    exp_rd.push_back(e);
    msk_rd.push_back(m);
    apb(1'b0, a, 32'h0000_0000);
  endtask : rd

  task automatic st(input int set, input int care);
    rd(dpu_pkg::OFS_STAT, 33'(set), 33'(care));
  endtask : st

  task automatic cr(input int bits);
    apb(1'b1, dpu_pkg::OFS_CTRL, 32'(bits));
  endtask : cr

  task automatic set_mode(input logic [2:0] m);
    mode = m;
    par_en <= !m[2];
    apb(1'b1, dpu_pkg::OFS_MODE, 32'(m) << dpu_pkg::MR_PAR_LO);
  endtask : set_mode

  // even parity bit is the xor of the data
  task automatic tx1(input logic [7:0] d);
    logic p;
    case (mode)
      3'h0: p = ^d;
      3'h1: p = ~^d;
      3'h3: p = 1'b1;
      default: p = 1'b0;
    endcase
    exp_tx.push_back({1'b1, p, d});
    apb(1'b1, dpu_pkg::OFS_THR, {24'h00_0000, d});
  endtask : tx1

  task automatic wait_tx();
    while (exp_tx.size() != 0) @(posedge pclk);
    repeat (BC) @(posedge pclk);
  endtask : wait_tx

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask : done

  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    logic [7:0] d;
    void'($urandom(32'h2a53));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(dpu_pkg::OFS_MODE, 33'h0, {33{1'b1}});
    rd(dpu_pkg::OFS_DIV, 33'h0, {33{1'b1}});
    st(0, RR | TR | TE);
    rd(12'h024, 33'h1_0000_0000, {33{1'b1}});
    apb(1'b1, dpu_pkg::OFS_DIV, 32'h0001_FFFF);
    rd(dpu_pkg::OFS_DIV, 33'h0_0000_FFFF, {33{1'b1}});
    apb(1'b1, dpu_pkg::OFS_DIV, 32'(DIV));
    cr(1 << dpu_pkg::CR_TX_EN | 1 << dpu_pkg::CR_RX_EN);
    st(TR, TR);
    done("reset");
    for (int m = 0; m < 5; m++) begin
      set_mode(3'(m));
      tx1(8'($urandom));
      wait_tx();
    end
    st(TR | TE, TR | TE);
    tx1(8'h0F);
    tx1(8'hA5);
    st(0, TR | TE);
    cr(1 << dpu_pkg::CR_TX_DIS);
    wait_tx();
    apb(1'b1, dpu_pkg::OFS_THR, 32'h0000_0033);
    repeat (12 * BC) @(posedge pclk);
    cr(1 << dpu_pkg::CR_TX_EN);
    st(TR | TE, TR | TE);
    done("transmit");
    set_mode(3'h0);
    d = 8'($urandom);
    hm.send(d, ^d, 1'b1);
    st(RR, RR | ERR);
    rd(dpu_pkg::OFS_RHR, {25'h0, d}, {33{1'b1}});
    st(0, RR);
    hm.send(8'h3C, 1'b1, 1'b1);
    hm.send(8'h81, 1'b0, 1'b0);
    repeat (12 * BC) @(posedge pclk);
    st(RR | ERR, RR | ERR);
    cr(1 << dpu_pkg::CR_CLR_ERR);
    rd(dpu_pkg::OFS_RHR, 33'h0_0000_0081, {33{1'b1}});
    st(0, RR | ERR);
    hm.pulse(7 * DIV);
    repeat (12 * BC) @(posedge pclk);
    st(0, RR | ERR);
    done("receive");
    fork
      hm.send(8'h5A, 1'b0, 1'b1);
      begin
        repeat (4 * BC) @(posedge pclk);
        cr(1 << dpu_pkg::CR_RX_RST);
      end
    join
    st(0, RR | ERR);
    cr(1 << dpu_pkg::CR_RX_EN | 1 << dpu_pkg::CR_RX_DIS);
    hm.send(8'h5A, 1'b0, 1'b1);
    st(0, RR);
    cr(1 << dpu_pkg::CR_RX_EN);
    fork
      hm.send(8'h96, 1'b0, 1'b1);
      begin
        repeat (4 * BC) @(posedge pclk);
        cr(1 << dpu_pkg::CR_RX_DIS);
      end
    join
    st(RR, RR | ERR);
    rd(dpu_pkg::OFS_RHR, 33'h0_0000_0096, {33{1'b1}});
    done("receiver control");
    apb(1'b1, dpu_pkg::OFS_DIV, 32'h0000_0000);
    apb(1'b1, dpu_pkg::OFS_THR, 32'h0000_0077);
    repeat (12 * BC) @(posedge pclk);
    chk({32'h0, tx_line}, 33'h1, 33'h1);
    done("divisor zero");
    conclude();
  end

  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    $display("ERROR %0t watchdog expired", $time);
    conclude();
  end
endmodule : dpu_uart_tb_top
